// ==== hdl/sleep_wakeup_controller.sv ====
// Power-down controller: sleep entry, wake-up, flags, interrupt vectoring.
// Assumes the instruction sequencer on clk_i and asynchronous pin inputs.
// Functional notes
// R1: Sleep clears watchdog, clears pd, sets to.
// R2: Oscillator driver off while asleep.
// R3: Pins hold their state while asleep.
// R4: Master-clear pin held high to stay asleep.
// R5: Wake on master clear, watchdog, interrupt.
// R6: Master clear resets; others resume execution.
// R7: Power-up sets pd; sleep clears it.
// R8: Watchdog wake-up clears the to flag.
// R9: Listed peripheral interrupts can wake device.
// R10: Other peripherals masked while asleep.
// R11: Sleep prefetches the next program address.
// R12: Wake needs individual enable, ignores global.
// R13: Global enable set: next instruction, then vector.
// R14: Software may put a no-op after sleep.
// R15: Pending interrupt turns sleep into no-op.
// R16: Interrupt during sleep: finish it, wake.
// R17: Software clears watchdog before sleep.
// R18: Interrupt clears global enable, pushes, vectors.
// R19: Running time-out resets; asleep time-out wakes.
// R20: Watchdog clear and sleep clear watchdog.
// R21: Crystal wake waits for oscillator start-up; a master-clear wake here goes straight to ST_RUN with the clock on at once.
//
// The Wishbone interface to the registers was decided locally.
`default_nettype none
module sleep_wakeup_controller (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [sleep_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [sleep_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [sleep_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [sleep_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          sleep_exec_i,
  input  wire logic                          wdt_clear_i,
  input  wire logic                          instr_done_i,
  input  wire logic [sleep_pkg::PC_W-1:0]    pc_i,
  input  wire logic                          master_clear_pin_n_i,
  input  wire logic                          ext_int_flag_i,
  input  wire logic                          port_b_change_i,
  input  wire logic [sleep_pkg::N_WAKE-1:0]  wake_periph_flag_i,
  input  wire logic                          other_periph_flag_i,
  input  wire logic                          wdt_rc_tick_i,
  output logic                               osc_drive_en_o,
  output logic                               core_clk_en_o,
  output logic                               pin_hold_o,
  output logic                               device_reset_o,
  output logic      [sleep_pkg::PC_W-1:0]    prefetch_addr_o,
  output logic                               vector_load_o,
  output logic      [sleep_pkg::PC_W-1:0]    vector_addr_o,
  output logic                               stack_push_o,
  output logic      [sleep_pkg::PC_W-1:0]    return_addr_o
);
  import sleep_pkg::*;

  wdt_if wd ();                                   // Watchdog link
  logic [N_SYNC-1:0] sync_w;                      // Synchronised pins
  logic              master_clear_pin_low, ext_s, rbc_s, oth_s;
  logic [N_WAKE-1:0] per_s;

  // Pin synchronisers
  pin_sync #(.WIDTH(N_SYNC)) u_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i ({wdt_rc_tick_i, other_periph_flag_i, wake_periph_flag_i,
               port_b_change_i, ext_int_flag_i, ~master_clear_pin_n_i}),
    .sync_o  (sync_w)
  );
  assign master_clear_pin_low = sync_w[0];
  assign ext_s    = sync_w[1];
  assign rbc_s    = sync_w[2];
  assign per_s    = sync_w[N_WAKE+2:3];
  assign oth_s    = sync_w[N_WAKE+3];

  // Watchdog
  watchdog_core u_wdt (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .w      (wd.wdt)
  );

  pwr_state_t        state_reg, state_next;       // Power state
  logic              pd_reg, pd_next;             // Power-down flag
  logic              to_reg, to_next;             // Time-out flag
  logic [7:0]        cfg_reg, cfg_next;           // Configuration word
  logic [7:0]        opt_reg, opt_next;           // Option settings
  logic [7:0]        irqc_reg, irqc_next;         // Interrupt control
  logic [N_WAKE-1:0] pie_reg, pie_next;           // Peripheral enables
  logic [OST_W-1:0]  ost_reg, ost_next;           // Start-up counter
  logic              vecp_reg, vecp_next;         // Vector after next instruction
  logic              ack_reg, ack_next;           // Bus acknowledge
  logic [DAT_W-1:0]  rdat_reg, rdat_next;         // Bus read data
  logic [PC_W-1:0]   pref_reg, pref_next;         // Prefetch address
  logic [PC_W-1:0]   ret_reg, ret_next;           // Return address
  logic              rst_reg, rst_next;           // Device reset pulse
  logic              vec_reg, vec_next;           // Vector load pulse
  logic              osc_reg, osc_next;           // Oscillator driver on
  logic              clk_reg, clk_next;           // Instruction clock on
  logic              hold_reg, hold_next;         // Pin hold
  logic              wake_pend, irq_pend, crystal, bus_req, bus_wr;

  // Enabled interrupt sources; globals do not gate wake-up
  always_comb begin
    wake_pend = (ext_s & irqc_reg[INTE_BIT]) | (rbc_s & irqc_reg[RBIE_BIT])  // [R12]
              | (irqc_reg[PEIE_BIT] & |(per_s & pie_reg));                   // [R9]
    // Non-wake peripherals only count while the clock runs [R10]
    irq_pend  = wake_pend | (irqc_reg[PEIE_BIT] & oth_s & (state_reg == ST_RUN));
    crystal   = cfg_reg[CFG_FOSC_LO +: 2] != FOSC_RC;
    bus_req   = wb_cyc_i & wb_stb_i;
    bus_wr    = bus_req & ack_reg & wb_we_i & wb_sel_i[0];
  end

  // Next-state logic of the power sequence and the register file
  always_comb begin
    state_next = state_reg;
    pd_next    = pd_reg;
    to_next    = to_reg;
    cfg_next   = cfg_reg;
    opt_next   = opt_reg;
    irqc_next  = irqc_reg;
    pie_next   = pie_reg;
    ost_next   = ost_reg;
    vecp_next  = vecp_reg;
    pref_next  = pref_reg;
    ret_next   = ret_reg;
    rst_next   = 1'b0;
    vec_next   = 1'b0;
    wd.clear   = wdt_clear_i;                         // [R20]
    // Register writes take effect at the acknowledging edge
    if (bus_wr) begin
      unique case (wb_adr_i)
        byte_adr(CFG_IDX):  cfg_next  = wb_dat_i[7:0];
        byte_adr(OPT_IDX):  opt_next  = wb_dat_i[7:0];
        byte_adr(IRQC_IDX): irqc_next = wb_dat_i[7:0];
        byte_adr(PIE_IDX): begin
          pie_next[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) begin
            pie_next[N_WAKE-1] = wb_dat_i[N_WAKE-1];
          end
        end
        default: ;                                    // Unmapped: ignored
      endcase
    end
    unique case (state_reg)
      // Running: resets, sleep entry and normal interrupts
      ST_RUN: begin
        if (wd.timeout) begin                         // Time-out resets [R19]
          to_next  = 1'b0;                            // [R8]
          rst_next = 1'b1;
          irqc_next[GIE_BIT] = 1'b0;
        end else if (sleep_exec_i) begin
          if (!wake_pend) begin                       // Else acts as no-op [R15]
            wd.clear   = 1'b1;                        // [R1]
            pd_next    = 1'b0;                        // [R1] [R7]
            to_next    = 1'b1;                        // [R1]
            pref_next  = pc_i + PC_STEP;              // [R11]
            state_next = ST_SLEEP;                    // [R2] [R3]
          end
        end else if (irqc_reg[GIE_BIT] && irq_pend && instr_done_i) begin
          irqc_next[GIE_BIT] = 1'b0;                  // [R18]
          vec_next = 1'b1;
          ret_next = pc_i;
        end
      end
      // Asleep: wait for one of the wake events [R5]
      ST_SLEEP: begin
        if (wd.timeout || wake_pend) begin            // [R16] [R19]
          if (wd.timeout) begin
            to_next = 1'b0;                           // [R8]
          end
          vecp_next  = irqc_reg[GIE_BIT] & wake_pend;  // [R13]
          ost_next   = '0;
          state_next = crystal ? ST_OST : ST_RESUME;  // [R21]
        end
      end
      // Oscillator start-up delay before the clock is released
      ST_OST: begin
        ost_next = ost_reg + OST_ONE;                 // [R21]
        if (ost_reg == OST_LAST) begin
          state_next = ST_RESUME;
        end
      end
      // Resumed: run the prefetched instruction, then maybe vector
      ST_RESUME: begin
        if (!vecp_reg) begin                          // In-line continue [R13]
          state_next = ST_RUN;
        end else if (instr_done_i) begin
          irqc_next[GIE_BIT] = 1'b0;                  // [R13] [R18]
          vec_next   = 1'b1;
          ret_next   = pc_i;
          vecp_next  = 1'b0;
          state_next = ST_RUN;
        end
      end
    endcase
    // Master clear overrides state, pending vector and global enable: full reset, flags untouched [R6]
    if (master_clear_pin_low) begin
      rst_next   = 1'b1;
      vecp_next  = 1'b0;
      irqc_next[GIE_BIT] = 1'b0;
      state_next = ST_RUN;
    end
    osc_next  = state_next != ST_SLEEP;               // [R2]
    clk_next  = (state_next == ST_RUN) || (state_next == ST_RESUME);
    hold_next = (state_next == ST_SLEEP) || (state_next == ST_OST);  // [R3]
  end

  // Bus answer: one wait state, read data sampled on the request
  always_comb begin
    ack_next  = bus_req & ~ack_reg;
    rdat_next = rdat_reg;
    if (bus_req && !ack_reg) begin
      rdat_next = '0;                                 // Unmapped reads zero
      unique case (wb_adr_i)
        byte_adr(CFG_IDX):  rdat_next[7:0] = cfg_reg;
        byte_adr(OPT_IDX):  rdat_next[7:0] = opt_reg;
        byte_adr(IRQC_IDX): rdat_next[7:0] = irqc_reg;
        byte_adr(PIE_IDX):  rdat_next[N_WAKE-1:0] = pie_reg;
        byte_adr(STAT_IDX): begin
          rdat_next[STAT_PD_BIT] = pd_reg;
          rdat_next[STAT_TO_BIT] = to_reg;
        end
        default: ;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin                                 // Power-up sets pd and to [R7]
      state_reg <= ST_RUN;
      pd_reg    <= 1'b1;
      to_reg    <= 1'b1;
      cfg_reg   <= CFG_RST;
      opt_reg   <= OPT_RST;
      irqc_reg  <= IRQC_RST;
      pie_reg   <= PIE_RST;
      ost_reg   <= '0;
      vecp_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      rdat_reg  <= '0;
      pref_reg  <= '0;
      ret_reg   <= '0;
      rst_reg   <= 1'b0;
      vec_reg   <= 1'b0;
      osc_reg   <= 1'b1;
      clk_reg   <= 1'b1;
      hold_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pd_reg    <= pd_next;
      to_reg    <= to_next;
      cfg_reg   <= cfg_next;
      opt_reg   <= opt_next;
      irqc_reg  <= irqc_next;
      pie_reg   <= pie_next;
      ost_reg   <= ost_next;
      vecp_reg  <= vecp_next;
      ack_reg   <= ack_next;
      rdat_reg  <= rdat_next;
      pref_reg  <= pref_next;
      ret_reg   <= ret_next;
      rst_reg   <= rst_next;
      vec_reg   <= vec_next;
      osc_reg   <= osc_next;
      clk_reg   <= clk_next;
      hold_reg  <= hold_next;
    end
  end

  // Watchdog controls from the fuse and option settings
  assign wd.enable = cfg_reg[CFG_WATCHDOG_ENABLE_FUSE_BIT];
  assign wd.prescaler_assign    = opt_reg[OPT_PSA_BIT];
  assign wd.ps     = opt_reg[OPT_PS_LO +: 3];
  assign wd.tick   = sync_w[N_SYNC-1];

  // Outputs
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdat_reg;
  assign osc_drive_en_o  = osc_reg;
  assign core_clk_en_o   = clk_reg;
  assign pin_hold_o      = hold_reg;
  assign device_reset_o  = rst_reg;
  assign prefetch_addr_o = pref_reg;
  assign vector_load_o   = vec_reg;
  assign vector_addr_o   = IRQ_VECTOR;                // [R18]
  assign stack_push_o    = vec_reg;
  assign return_addr_o   = ret_reg;

  // Checks
  sequence s_sleep_go;
    state_reg == ST_RUN && sleep_exec_i && !wake_pend && !wd.timeout && !master_clear_pin_low;
  endsequence
  sequence s_sleep_nop;
    state_reg == ST_RUN && sleep_exec_i && wake_pend && !wd.timeout && !master_clear_pin_low;
  endsequence

  a_sleep_flags: assert property (@(posedge clk_i) disable iff (srst_i) // [R1]
    s_sleep_go |=> !pd_reg && to_reg && state_reg == ST_SLEEP)
    else $error("sleep entry did not update flags");
  a_osc_off_sleep: assert property (@(posedge clk_i) disable iff (srst_i) // [R2]
    s_sleep_go |=> !osc_drive_en_o && !core_clk_en_o)
    else $error("oscillator still driven while asleep");
  a_pins_held: assert property (@(posedge clk_i) disable iff (srst_i) // [R3]
    state_reg == ST_SLEEP |-> pin_hold_o)
    else $error("pins not held while asleep");
  a_master_clear_pin_reset: assert property (@(posedge clk_i) disable iff (srst_i) // [R6]
    master_clear_pin_low |=> device_reset_o && state_reg == ST_RUN)
    else $error("master clear did not reset");
  a_wdt_wake_to: assert property (@(posedge clk_i) disable iff (srst_i) // [R8]
    state_reg == ST_SLEEP && wd.timeout && !master_clear_pin_low |=> !to_reg && !device_reset_o)
    else $error("watchdog wake did not clear to flag");
  a_sleep_nop: assert property (@(posedge clk_i) disable iff (srst_i) // [R15]
    s_sleep_nop |=> $stable(pd_reg) && $stable(to_reg) && state_reg == ST_RUN)
    else $error("sleep with pending interrupt was not a no-op");
  a_vector_gie: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
    $rose(vector_load_o) |-> !irqc_reg[GIE_BIT] && stack_push_o)
    else $error("vector without clearing global enable");
  a_ost_wait: assert property (@(posedge clk_i) disable iff (srst_i) // [R21]
    state_reg == ST_SLEEP && crystal && wake_pend && !master_clear_pin_low |=>
      state_reg == ST_OST ##1 !core_clk_en_o [*8])
    else $error("clock released before start-up delay");
  a_prefetch: assert property (@(posedge clk_i) disable iff (srst_i) // [R11]
    s_sleep_go |=> prefetch_addr_o == $past(pc_i) + PC_STEP)
    else $error("prefetch address is not the next one");
endmodule
`default_nettype wire

// ==== hdl/sleep_pkg.sv ====
// Package: constants, register map and state type of the power-down controller.
// Assumes a single 200 MHz clock and the classic Wishbone register bus.
`default_nettype none
package sleep_pkg;
  // Bus widths
  localparam int ADR_W  = 16;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = 4;
  localparam int PC_W   = 13;
  localparam int N_WAKE = 9;                // Wake-capable peripheral flags
  localparam int N_SYNC = N_WAKE + 5;       // All pin inputs through synchronisers
  // Register indices; byte address is four times the index
  localparam logic [ADR_W-1:0] CFG_IDX  = 16'h2007;
  localparam logic [ADR_W-1:0] OPT_IDX  = 16'h0081;
  localparam logic [ADR_W-1:0] STAT_IDX = 16'h0003;
  localparam logic [ADR_W-1:0] IRQC_IDX = 16'h000b;
  localparam logic [ADR_W-1:0] PIE_IDX  = 16'h008c;
  // Field positions
  localparam int STAT_PD_BIT  = 3;
  localparam int STAT_TO_BIT  = 4;
  localparam int CFG_WATCHDOG_ENABLE_FUSE_BIT = 2;
  localparam int CFG_FOSC_LO  = 0;
  localparam int OPT_PSA_BIT  = 3;
  localparam int OPT_PS_LO    = 0;
  localparam int GIE_BIT      = 7;
  localparam int PEIE_BIT     = 6;
  localparam int INTE_BIT     = 4;
  localparam int RBIE_BIT     = 3;
  // Reset values and encodings
  localparam logic [7:0]        CFG_RST  = 8'hff;
  localparam logic [7:0]        OPT_RST  = 8'hff;
  localparam logic [7:0]        IRQC_RST = 8'h00;
  localparam logic [N_WAKE-1:0] PIE_RST  = 9'h000;
  localparam logic [1:0]        FOSC_RC  = 2'h3;
  localparam logic [PC_W-1:0]   IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;
  // Oscillator start-up delay
  localparam int OST_OSC_PERIODS = 1024;
  localparam int OSC_PERIOD_NS   = 5;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int OST_CYCLES =
    (OST_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_W = 11;
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_CYCLES - 1);
  localparam logic [OST_W-1:0] OST_ONE  = 11'h001;
  // Watchdog widths
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  // Power states
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST, ST_RESUME} pwr_state_t;
  // Byte address of a register index
  function automatic logic [ADR_W-1:0] byte_adr(input logic [ADR_W-1:0] idx);
    byte_adr = {idx[ADR_W-3:0], 2'b00};
  endfunction
endpackage
`default_nettype wire

// ==== hdl/wdt_if.sv ====
// Interface: control and status between the controller and its watchdog.
// Assumes both ends run on the same clock.
`default_nettype none
interface wdt_if;
  logic       clear;     // Clear count and prescaler
  logic       enable;    // Watchdog enable fuse
  logic       prescaler_assign;       // Prescaler assigned to the watchdog
  logic [2:0] ps;        // Prescale select
  logic       tick;      // Synchronised RC oscillator level
  logic       timeout;   // One-cycle time-out pulse
  modport ctrl (output clear, enable, prescaler_assign, ps, tick, input timeout);
  modport wdt  (input clear, enable, prescaler_assign, ps, tick, output timeout);
endinterface
`default_nettype wire

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to clk_i.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;   // First stage, read only by second
  logic [WIDTH-1:0] stab_reg;   // Second stage

  // Shift the pins through two flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= '0;
      stab_reg <= '0;
    end else begin
      meta_reg <= async_i;
      stab_reg <= meta_reg;
    end
  end
  assign sync_o = stab_reg;
endmodule
`default_nettype wire

// ==== hdl/watchdog_core.sv ====
// Watchdog counter with optional prescaler, ticked by its RC oscillator.
// Assumes the tick level is already synchronised to clk_i.
`default_nettype none
module watchdog_core (
  input  wire logic clk_i,
  input  wire logic srst_i,
  wdt_if.wdt        w
);
  import sleep_pkg::*;
  logic [WDT_W-1:0] cnt_reg, cnt_next;     // Base count
  logic [PRE_W-1:0] pre_reg, pre_next;     // Prescaler count
  logic             tick_reg, tick_next;   // Last tick level
  logic             to_reg, to_next;       // Time-out pulse
  logic [PRE_W-1:0] mask;                  // Prescaler terminal mask
  logic             edge_seen, base_tick;

  // Count RC ticks, scale them and flag the wrap of the base count
  always_comb begin
    mask      = PRE_W'((9'h001 << w.ps) - 9'h001);
    edge_seen = w.tick & ~tick_reg;
    base_tick = edge_seen & (~w.prescaler_assign | ((pre_reg & mask) == mask));
    tick_next = w.tick;
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    to_next   = 1'b0;
    if (!w.enable || w.clear) begin          // Clear keeps it running [R20] [R1]
      pre_next = '0;
      cnt_next = '0;
    end else if (edge_seen) begin
      pre_next = base_tick ? '0 : pre_reg + PRE_W'(1);
      if (base_tick) begin
        cnt_next = cnt_reg + WDT_W'(1);
        to_next  = &cnt_reg;
      end
    end
  end

  // Register watchdog state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg  <= '0;
      pre_reg  <= '0;
      tick_reg <= 1'b0;
      to_reg   <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
      to_reg   <= to_next;
    end
  end
  assign w.timeout = to_reg;

  a_clear_stops_to: assert property (@(posedge clk_i) disable iff (srst_i) // [R20]
    w.clear |=> !w.timeout)
    else $error("watchdog timed out right after a clear");
endmodule
`default_nettype wire

// ==== tb/seq_model.sv ====
// Model of the instruction sequencer and of the free-running watchdog RC oscillator.
// Assumes the controller's clock; instructions issue only while the core clock is enabled.
`default_nettype none
module seq_model (
  input  wire logic                     clk_i,
  input  wire logic                     core_clk_en_i,
  output var  logic                     sleep_exec_o,
  output var  logic                     wdt_clear_o,
  output var  logic                     instr_done_o,
  output var  logic [sleep_pkg::PC_W-1:0] pc_o,
  output logic                          rc_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_pkg::*;
  logic [1:0] rc_div = 2'h0; // RC oscillator divider, one rise every 4 cycles
  initial begin
    sleep_exec_o = 1'b0;
    wdt_clear_o  = 1'b0;
    instr_done_o = 1'b0;
    pc_o         = '0;
  end
  // The watchdog oscillator runs free, asleep or not
  always @(posedge clk_i) begin
    rc_div <= rc_div + 2'h1;
  end
  assign rc_tick_o = rc_div[1];
  // Issue one instruction: 0 power-down, 1 watchdog clear, 2 any other
  task automatic exec(input int kind, input logic [PC_W-1:0] pc);
    @(posedge clk_i);
    while (!core_clk_en_i) @(posedge clk_i); // No fetch while clock gated
    pc_o         <= pc;
    sleep_exec_o <= (kind == 0);
    wdt_clear_o  <= (kind == 1);
    instr_done_o <= (kind == 2);
    @(posedge clk_i);
    sleep_exec_o <= 1'b0;
    wdt_clear_o  <= 1'b0;
    instr_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/sleep_wakeup_controller_tb.sv ====
// Self-checking bench of the power-down controller.
// Assumes the package constants and the hand-over timing of the design.
`default_nettype none
module sleep_wakeup_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_pkg::*;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, is_rd = 0;
  logic [ADR_W-1:0] adr = '0;
  logic [SEL_W-1:0] sel = '0;
  logic [DAT_W-1:0] wdat = '0, rdat;
  logic ext = 0, pbc = 0, oth = 0, master_clear_pin_n = 1; // Pin held high to stay asleep
  logic [N_WAKE-1:0] wpf = '0;
  logic sx, wc, idn, tick, ack, osc, cke, hold, drst, vld, push;
  logic [PC_W-1:0] pc, pfa, vadr, radr, p;
  logic [31:0] seed = 32'hc331ad0a;
  logic [31:0] rq[$];      // Expected read data
  logic [PC_W-1:0] vq[$];  // Expected return addresses
  int bad_count = 0, compares = 0, cyc_n = 0, rst_seen = 0, k;
  always #2.5 clk = ~clk;
  sleep_wakeup_controller i_dut (.clk_i(clk), .srst_i(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sleep_exec_i(sx), .wdt_clear_i(wc), .instr_done_i(idn), .pc_i(pc),
    .master_clear_pin_n_i(master_clear_pin_n), .ext_int_flag_i(ext), .port_b_change_i(pbc),
    .wake_periph_flag_i(wpf), .other_periph_flag_i(oth), .wdt_rc_tick_i(tick),
    .osc_drive_en_o(osc), .core_clk_en_o(cke), .pin_hold_o(hold), .device_reset_o(drst),
    .prefetch_addr_o(pfa), .vector_load_o(vld), .vector_addr_o(vadr), .stack_push_o(push),
    .return_addr_o(radr));
  seq_model i_seq (.clk_i(clk), .core_clk_en_i(cke), .sleep_exec_o(sx), .wdt_clear_o(wc),
    .instr_done_o(idn), .pc_o(pc), .rc_tick_o(tick));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [ADR_W-1:0] a4(input logic [ADR_W-1:0] idx);
    a4 = idx << 2;
  endfunction
  function automatic logic [31:0] st(input logic d, input logic t);
    st = (32'(t) << STAT_TO_BIT) | (32'(d) << STAT_PD_BIT);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One classic cycle, held until ack, then a cycle idle
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= 32'(d);
    sel <= 4'hf;
    is_rd <= !w;
    @(posedge clk);
    while (!ack) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    is_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, a, 16'h0);
  endtask
  task automatic wt();
    while (!cke) @(posedge clk);
  endtask
  // Output watcher: read data, vectoring, reset pulses, timeout
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 12000) begin
      bad_count++;
      complete_run();
    end else begin
      if (ack && is_rd) chk(rdat, rq.pop_front());
      if (vld || push) chk({vld, push, vadr, radr}, {2'b11, IRQ_VECTOR, vq.pop_front()});
      if (drst) rst_seen++;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(a4(STAT_IDX), st(1, 1));
    rd(a4(CFG_IDX), 32'(CFG_RST));
    rd(a4(OPT_IDX), 32'(OPT_RST));
    rd(a4(16'h0100), 32'h0);
    bus(1'b1, a4(IRQC_IDX), 16'h0018);
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    i_seq.exec(0, 13'h0);
    repeat (4) @(posedge clk);
    chk(osc, 1'b1);
    rd(a4(STAT_IDX), st(1, 1));
    ext <= 1'b0;
    repeat (4) @(posedge clk);
    seed = lfsr(seed);
    p = seed[PC_W-1:0];
    i_seq.exec(0, p);
    repeat (3) @(posedge clk);
    chk({osc, cke, hold}, 3'b001);
    chk(pfa, p + PC_STEP);
    rd(a4(STAT_IDX), st(0, 1));
    oth <= 1'b1;
    wpf <= seed[20:12];
    repeat (8) @(posedge clk);
    chk(cke, 1'b0);
    pbc <= 1'b1;
    wt();
    chk(hold, 1'b0);
    i_seq.exec(2, p);
    {ext, pbc, oth, wpf} <= '0;
    seed = lfsr(seed);
    k = seed % N_WAKE;
    bus(1'b1, a4(PIE_IDX), 16'(1 << k));
    bus(1'b1, a4(IRQC_IDX), 16'h00c0);
    i_seq.exec(0, p);
    repeat (3) @(posedge clk);
    wpf <= N_WAKE'(1 << k);
    wt();
    vq.push_back(seed[PC_W-1:0]);
    i_seq.exec(2, seed[PC_W-1:0]);
    repeat (3) @(posedge clk);
    rd(a4(IRQC_IDX), 32'h40);
    wpf <= '0;
    repeat (4) @(posedge clk);
    i_seq.exec(0, p);
    repeat (3) @(posedge clk);
    master_clear_pin_n <= 1'b0;
    while (!drst) @(posedge clk);
    master_clear_pin_n <= 1'b1;
    wt();
    rd(a4(STAT_IDX), st(0, 1));
    bus(1'b1, a4(OPT_IDX), 16'h0008);
    i_seq.exec(1, p);
    i_seq.exec(0, p);
    repeat (3) @(posedge clk);
    chk(cke, 1'b0);
    wt();
    rd(a4(STAT_IDX), st(0, 0));
    rst_seen = 0;
    repeat (3) begin
      repeat (600) @(posedge clk);
      i_seq.exec(1, p);
    end
    chk(32'(rst_seen), 32'h0);
    while (rst_seen == 0) @(posedge clk);
    // Crystal oscillator, watchdog off: wake waits out the start-up delay
    bus(1'b1, a4(CFG_IDX), 16'h00f8);
    bus(1'b1, a4(IRQC_IDX), 16'h0010);
    i_seq.exec(0, p);
    repeat (3) @(posedge clk);
    ext <= 1'b1;
    k = 0;
    while (!cke) begin
      @(posedge clk);
      k++;
    end
    // Two synchroniser edges, one wake edge, one edge of sampling lag
    chk(32'(k), 32'(OST_CYCLES + 4));
    chk(hold, 1'b0);
    ext <= 1'b0;
    chk(32'(rq.size() + vq.size()), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
